/* File: design/ssg_pkg.sv */
package ssg_pkg;

  // ************************************************************
  // Sizes and timing
  // ************************************************************
  localparam int NPT = 8;
  localparam int SCL_IW = 3;
  localparam int ADDR_W = 8;
  localparam int CLK_HZ = 10_000_000;
  localparam int SEC_S = 1;
  localparam int SEC_CYCLES = SEC_S * CLK_HZ;
  localparam int ESD_ACK_S = 5;
  localparam int ESD_ACK_CYCLES = ESD_ACK_S * CLK_HZ;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_NODE = 8'h04;
  localparam logic [7:0] OFF_TMO = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0c;
  localparam logic [7:0] OFF_ERR = 8'h10;
  localparam logic [7:0] OFF_CMD = 8'h14;
  localparam logic [7:0] OFF_SCL = 8'h20;
  // Control bit positions; port b sits one stride above port a
  localparam int CB_USE = 0;
  localparam int CB_WR = 1;
  localparam int CB_WRLOC = 2;
  localparam int CB_ESD = 3;
  localparam int CB_ESDLOC = 4;
  localparam int CB_ASCII = 5;
  localparam int CB_STRIDE = 8;
  localparam int CB_LRCFG = 16;
  localparam int CB_TWOSTEP = 17;
  localparam int CMD_CLR = 0;
  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [7:0] NODE_RST = 8'h01;
  localparam logic [15:0] TMO_RST = 16'h000a;
  localparam logic [15:0] SCL_RST = 16'h0100;

  // ************************************************************
  // Link coding
  // ************************************************************
  localparam logic signed [15:0] LINK_MAX = 16'sh7fff;
  localparam logic [2:0] PFX_COIL = 3'h0;
  localparam logic [2:0] PFX_STAT = 3'h1;
  localparam logic [2:0] PFX_IREG = 3'h3;
  localparam logic [2:0] PFX_HREG = 3'h4;
  localparam logic [15:0] IDX_ESD = 16'h0001;
  localparam logic [15:0] IDX_ESD_ACK = 16'h0002;
  localparam logic [7:0] ERR_ILL_FN = 8'h01;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic valid;
    logic err;
    logic [7:0] err_code;
    logic [7:0] node;
    logic [2:0] pfx;
    logic [15:0] index;
    logic [15:0] data;
  } ssg_req_s;

  typedef struct packed {
    logic use_port;
    logic wr_en;
    logic wr_loc_en;
    logic esd_en;
    logic esd_loc_en;
    logic [7:0] node;
    logic [15:0] tmo_s;
  } ssg_cfg_s;

  typedef struct packed {
    logic rd;
    logic coil_wr;
    logic hold_wr;
    logic emergency_shutdown_command;
    logic esd_ack;
  } ssg_act_s;

  typedef struct packed {
    logic [15:0] idle_s;
    logic alarm;
    logic err;
    logic [7:0] code;
  } ssg_port_s;

  typedef struct packed {
    logic valid;
    logic [15:0] data;
  } ssg_rsp_s;

  typedef struct packed {
    logic coil_valid;
    logic hold_valid;
    logic [15:0] index;
    logic coil_value;
    logic [31:0] hold_value;
  } ssg_cmd_s;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [15:0] node;
    logic [31:0] tmo;
    logic [NPT-1:0][15:0] scl;
    logic awrdy;
    logic wrdy;
    logic arrdy;
    logic aw_have;
    logic w_have;
    logic bvalid;
    logic rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic clr;
    logic [31:0] sec_cnt;
    logic sec_tick;
    logic esd_armed;
    logic [31:0] esd_cnt;
    logic esd_trip;
    logic [1:0][16:0] rsp;
    logic [1:0][50:0] cmd;
  } ssg_top_s;

endpackage

/* File: design/ssg_port.sv */
`timescale 1ns/1ns
module ssg_port (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire ssg_pkg::ssg_req_s req_in,
  input wire ssg_pkg::ssg_cfg_s cfg_in,
  input wire logic lr_cfg_in,
  input wire logic remote_in,
  input wire logic sec_tick_in,
  input wire logic clr_in,
  output ssg_pkg::ssg_act_s act_out,
  output ssg_pkg::ssg_port_s stat_out
);

  // Local/remote gate shared by coil writes and shutdown
  function automatic logic lr_ok(input logic cfg, input logic remote, input logic loc_en);
    return !cfg || remote || loc_en;
  endfunction

  ssg_pkg::ssg_port_s st_reg;
  ssg_pkg::ssg_port_s st_next;
  logic mine;
  logic coil;
  logic wr_ok;
  logic esd_ok;
  logic legal;

  // Decide what the request may do, and update timer and error latch
  always_comb begin
    mine = req_in.valid && !req_in.err && (req_in.node == cfg_in.node);
    coil = mine && (req_in.pfx == ssg_pkg::PFX_COIL);
    legal = (req_in.pfx == ssg_pkg::PFX_COIL) || (req_in.pfx == ssg_pkg::PFX_STAT) ||
            (req_in.pfx == ssg_pkg::PFX_IREG) || (req_in.pfx == ssg_pkg::PFX_HREG);
    wr_ok = cfg_in.use_port && cfg_in.wr_en;
    esd_ok = cfg_in.use_port && cfg_in.esd_en && lr_ok(lr_cfg_in, remote_in, cfg_in.esd_loc_en);
    act_out.rd = mine && ((req_in.pfx == ssg_pkg::PFX_STAT) || (req_in.pfx == ssg_pkg::PFX_IREG));
    act_out.coil_wr = coil && wr_ok && lr_ok(lr_cfg_in, remote_in, cfg_in.wr_loc_en);
    act_out.hold_wr = mine && (req_in.pfx == ssg_pkg::PFX_HREG) && wr_ok;
    act_out.emergency_shutdown_command = coil && esd_ok && (req_in.index == ssg_pkg::IDX_ESD) && req_in.data[0];
    act_out.esd_ack = coil && esd_ok && (req_in.index == ssg_pkg::IDX_ESD_ACK) && req_in.data[0];
    st_next = st_reg;
    // Valid traffic for this node restarts the dead-time count
    if (mine || clr_in) begin
      st_next.idle_s = 16'h0;
    end else if (sec_tick_in && (st_reg.idle_s != 16'hffff)) begin
      st_next.idle_s = st_reg.idle_s + 16'h1;
    end
    if (clr_in) begin
      st_next.alarm = 1'b0;
      st_next.err = 1'b0;
      st_next.code = 8'h00;
    end
    // Sets come after the clear so a same-cycle event is kept
    if (st_reg.idle_s > cfg_in.tmo_s) begin
      st_next.alarm = 1'b1;
    end
    if (req_in.valid && req_in.err) begin
      st_next.err = 1'b1;
      st_next.code = req_in.err_code;
    end else if (mine && !legal) begin
      st_next.err = 1'b1;
      st_next.code = ssg_pkg::ERR_ILL_FN;
    end
  end

  // State register
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign stat_out = st_reg;

endmodule // ssg_port

/* File: design/ssg_top.sv */
// Register access over AXI4-Lite and the address map were decided locally.
`timescale 1ns/1ns
// Summary of operation
// - Device only answers; master starts everything
// - Coils and holding registers are master commands
// - Prefixes 0,1,3,4 select four data classes
// - Link integers limited to plus/minus 32767
// - Fraction dropped by truncation toward zero
// - Analog reads multiplied by point scalar
// - Analog writes multiplied by point scalar
// - Read data always current process values
// - Port disabled means reads only
// - Port write enable gates all writes; shutdown commands pass without it
// - Local mode blocks coil writes unless allowed
// - No local/remote config: local setting ignored
// - Per-port ASCII or RTU, RTU default
// - Per-port node address, default one
// - Link dead time beyond timeout raises alarm
// - Shutdown enable gates link shutdown
// - Local mode blocks shutdown unless allowed
// - Two-step: acknowledge within five seconds
// - Reset clears both ports' latched errors
// - Per-port readable last error code
module ssg_top #(
  parameter int SEC_CYCLES = ssg_pkg::SEC_CYCLES,
  parameter int ESD_ACK_CYCLES = ssg_pkg::ESD_ACK_CYCLES
) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic [7:0] axi_awaddr_in,
  input wire logic axi_awvalid_in,
  output logic axi_awready_out,
  input wire logic [31:0] axi_wdata_in,
  input wire logic [3:0] axi_wstrb_in,
  input wire logic axi_wvalid_in,
  output logic axi_wready_out,
  output logic [1:0] axi_bresp_out,
  output logic axi_bvalid_out,
  input wire logic axi_bready_in,
  input wire logic [7:0] axi_araddr_in,
  input wire logic axi_arvalid_in,
  output logic axi_arready_out,
  output logic [31:0] axi_rdata_out,
  output logic [1:0] axi_rresp_out,
  output logic axi_rvalid_out,
  input wire logic axi_rready_in,
  input wire ssg_pkg::ssg_req_s [1:0] req_in,
  input wire logic remote_mode_in,
  input wire logic [15:0] bool_status_in,
  input wire logic [ssg_pkg::NPT-1:0][31:0] proc_analog_in,
  output ssg_pkg::ssg_rsp_s [1:0] rsp_out,
  output ssg_pkg::ssg_cmd_s [1:0] cmd_out,
  output logic [1:0] transmission_mode_select_out,
  output logic [1:0] link_alarm_out,
  output logic emergency_shutdown_command_out
);

  // ************************************************************
  // Helper functions
  // ************************************************************

  // Scalar window decode, {hit, index}
  function automatic logic [ssg_pkg::SCL_IW:0] scl_sel(input logic [7:0] a);
    logic [7:0] d;
    d = a - ssg_pkg::OFF_SCL;
    scl_sel = {(a >= ssg_pkg::OFF_SCL) && (d[7:2] < 6'(ssg_pkg::NPT)) && (d[1:0] == 2'h0),
               d[ssg_pkg::SCL_IW+1:2]};
  endfunction

  // Byte-lane merge for partial writes
  function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
    wmerge = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        wmerge[b*8+:8] = nw[b*8+:8];
      end
    end
  endfunction

  // Engineering value (16.16) times scalar (8.8) to link integer
  function automatic logic [15:0] to_link(input logic signed [31:0] v, input logic [15:0] k);
    logic signed [48:0] p;
    logic signed [24:0] q;
    p = v * $signed({1'b0, k});
    q = p[48:24];
    // Floor plus one on a negative remainder gives truncation
    if (p[48] && (p[23:0] != 24'h0)) begin
      q = q + 25'sh1;
    end
    if (q > 25'(ssg_pkg::LINK_MAX)) begin
      q = 25'(ssg_pkg::LINK_MAX);
    end else if (q < -25'(ssg_pkg::LINK_MAX)) begin
      q = -25'(ssg_pkg::LINK_MAX);
    end
    to_link = q[15:0];
  endfunction

  // Link integer times scalar (8.8) back to 16.16; wraps past 16 bits
  function automatic logic [31:0] to_int(input logic [15:0] d, input logic [15:0] k);
    logic signed [15:0] c;
    logic signed [40:0] p;
    c = $signed(d);
    if (c < -ssg_pkg::LINK_MAX) begin
      c = -ssg_pkg::LINK_MAX;
    end
    p = c * $signed({1'b0, k});
    to_int = {p[23:0], 8'h00};
  endfunction

  // ************************************************************
  // Port gates
  // ************************************************************
  ssg_pkg::ssg_top_s s_reg;
  ssg_pkg::ssg_top_s s_next;
  ssg_pkg::ssg_cfg_s [1:0] cfg;
  ssg_pkg::ssg_act_s [1:0] act;
  ssg_pkg::ssg_port_s [1:0] pst;

  // One gate per serial port; both share reset and timebase
  for (genvar p = 0; p < 2; p++) begin : g_port
    assign cfg[p].use_port = s_reg.ctrl[p*ssg_pkg::CB_STRIDE+ssg_pkg::CB_USE];
    assign cfg[p].wr_en = s_reg.ctrl[p*ssg_pkg::CB_STRIDE+ssg_pkg::CB_WR];
    assign cfg[p].wr_loc_en = s_reg.ctrl[p*ssg_pkg::CB_STRIDE+ssg_pkg::CB_WRLOC];
    assign cfg[p].esd_en = s_reg.ctrl[p*ssg_pkg::CB_STRIDE+ssg_pkg::CB_ESD];
    assign cfg[p].esd_loc_en = s_reg.ctrl[p*ssg_pkg::CB_STRIDE+ssg_pkg::CB_ESDLOC];
    assign cfg[p].node = s_reg.node[p*8+:8];
    assign cfg[p].tmo_s = s_reg.tmo[p*16+:16];

    ssg_port u_port (
      .clk_in(clk_in),
      .rst_b_in(rst_b_in),
      .req_in(req_in[p]),
      .cfg_in(cfg[p]),
      .lr_cfg_in(s_reg.ctrl[ssg_pkg::CB_LRCFG]),
      .remote_in(remote_mode_in),
      .sec_tick_in(s_reg.sec_tick),
      .clr_in(s_reg.clr),
      .act_out(act[p]),
      .stat_out(pst[p])
    );
  end

  // ************************************************************
  // Next-state logic
  // ************************************************************
  logic [ssg_pkg::SCL_IW:0] wsel;
  logic [ssg_pkg::SCL_IW:0] rsel;
  logic whit;
  logic esd_any;
  logic ack_any;
  logic [31:0] rd_val;
  ssg_pkg::ssg_rsp_s rsp_n;
  ssg_pkg::ssg_cmd_s cmd_n;
  logic [ssg_pkg::SCL_IW-1:0] pt;

  always_comb begin
    s_next = s_reg;
    s_next.clr = 1'b0;
    s_next.esd_trip = 1'b0;
    wsel = scl_sel(s_reg.awaddr);
    rsel = scl_sel(axi_araddr_in);
    whit = 1'b0;
    rd_val = 32'h0;
    rsp_n = '0;
    cmd_n = '0;
    pt = '0;

    // Write channel: address and data taken in either order
    if (axi_awvalid_in && s_reg.awrdy) begin
      s_next.aw_have = 1'b1;
      s_next.awaddr = axi_awaddr_in;
    end
    if (axi_wvalid_in && s_reg.wrdy) begin
      s_next.w_have = 1'b1;
      s_next.wdata = axi_wdata_in;
      s_next.wstrb = axi_wstrb_in;
    end
    if (s_reg.bvalid && axi_bready_in) begin
      s_next.bvalid = 1'b0;
    end
    // Commit once both halves are held and no response is pending
    if (s_reg.aw_have && s_reg.w_have && !s_reg.bvalid) begin
      whit = 1'b1;
      unique case (s_reg.awaddr)
        ssg_pkg::OFF_CTRL: s_next.ctrl = wmerge(s_reg.ctrl, s_reg.wdata, s_reg.wstrb);
        ssg_pkg::OFF_NODE: s_next.node = 16'(wmerge({16'h0, s_reg.node}, s_reg.wdata, s_reg.wstrb));
        ssg_pkg::OFF_TMO: s_next.tmo = wmerge(s_reg.tmo, s_reg.wdata, s_reg.wstrb);
        ssg_pkg::OFF_STAT: whit = 1'b1;
        ssg_pkg::OFF_ERR: whit = 1'b1;
        ssg_pkg::OFF_CMD: s_next.clr = s_reg.wstrb[0] && s_reg.wdata[ssg_pkg::CMD_CLR];
        default: begin
          if (wsel[ssg_pkg::SCL_IW]) begin
            s_next.scl[wsel[ssg_pkg::SCL_IW-1:0]] =
              16'(wmerge({16'h0000, s_reg.scl[wsel[ssg_pkg::SCL_IW-1:0]]}, s_reg.wdata, s_reg.wstrb));
          end else begin
            whit = 1'b0;
          end
        end
      endcase
      s_next.aw_have = 1'b0;
      s_next.w_have = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp = whit ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_SLVERR;
    end
    s_next.awrdy = !s_next.aw_have && !s_next.bvalid;
    s_next.wrdy = !s_next.w_have && !s_next.bvalid;

    // Read channel: one read in flight, unmapped reads zero with SLVERR
    if (s_reg.rvalid && axi_rready_in) begin
      s_next.rvalid = 1'b0;
    end
    if (axi_arvalid_in && s_reg.arrdy) begin
      s_next.rresp = ssg_pkg::RESP_OKAY;
      unique case (axi_araddr_in)
        ssg_pkg::OFF_CTRL: rd_val = s_reg.ctrl;
        ssg_pkg::OFF_NODE: rd_val = {16'h0000, s_reg.node};
        ssg_pkg::OFF_TMO: rd_val = s_reg.tmo;
        ssg_pkg::OFF_STAT: rd_val = {27'h0, s_reg.esd_armed, pst[1].err, pst[0].err,
                                     pst[1].alarm, pst[0].alarm};
        ssg_pkg::OFF_ERR: rd_val = {16'h0000, pst[1].code, pst[0].code};
        ssg_pkg::OFF_CMD: rd_val = 32'h0;
        default: begin
          if (rsel[ssg_pkg::SCL_IW]) begin
            rd_val = {16'h0000, s_reg.scl[rsel[ssg_pkg::SCL_IW-1:0]]};
          end else begin
            s_next.rresp = ssg_pkg::RESP_SLVERR;
          end
        end
      endcase
      s_next.rdata = rd_val;
      s_next.rvalid = 1'b1;
    end
    s_next.arrdy = !s_next.rvalid;

    // One-second timebase for the link dead-time counters
    s_next.sec_tick = (s_reg.sec_cnt == 32'(SEC_CYCLES - 1));
    s_next.sec_cnt = s_next.sec_tick ? 32'h0 : s_reg.sec_cnt + 32'h1;

    // Answers and commands; only master requests reach here
    for (int p = 0; p < 2; p++) begin
      pt = req_in[p].index[ssg_pkg::SCL_IW-1:0];
      rsp_n.valid = act[p].rd;
      // Sampled live, never cached
      if (req_in[p].pfx == ssg_pkg::PFX_STAT) begin
        rsp_n.data = {15'h0000, bool_status_in[req_in[p].index[3:0]]};
      end else begin
        rsp_n.data = to_link(proc_analog_in[pt], s_reg.scl[pt]);
      end
      if (!act[p].rd) begin
        rsp_n.data = 16'h0000;
      end
      cmd_n.coil_valid = act[p].coil_wr;
      cmd_n.hold_valid = act[p].hold_wr;
      cmd_n.index = req_in[p].index;
      cmd_n.coil_value = req_in[p].data[0];
      cmd_n.hold_value = to_int(req_in[p].data, s_reg.scl[pt]);
      s_next.rsp[p] = rsp_n;
      s_next.cmd[p] = cmd_n;
    end

    // Shutdown: direct, or two-step with a bounded window
    esd_any = act[0].emergency_shutdown_command || act[1].emergency_shutdown_command;
    ack_any = act[0].esd_ack || act[1].esd_ack;
    if (s_reg.esd_armed) begin
      s_next.esd_cnt = s_reg.esd_cnt + 32'h1;
    end
    if (!s_reg.ctrl[ssg_pkg::CB_TWOSTEP]) begin
      s_next.esd_trip = esd_any;
      s_next.esd_armed = 1'b0;
    end else if (esd_any) begin
      // A repeated shutdown command restarts the window
      s_next.esd_armed = 1'b1;
      s_next.esd_cnt = 32'h0;
    end else if (s_reg.esd_armed && ack_any) begin
      s_next.esd_trip = 1'b1;
      s_next.esd_armed = 1'b0;
    end else if (s_reg.esd_armed && (s_reg.esd_cnt >= 32'(ESD_ACK_CYCLES - 1))) begin
      s_next.esd_armed = 1'b0;
    end
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      s_reg <= '0;
      s_reg.ctrl <= ssg_pkg::CTRL_RST;
      s_reg.node <= {ssg_pkg::NODE_RST, ssg_pkg::NODE_RST};
      s_reg.tmo <= {ssg_pkg::TMO_RST, ssg_pkg::TMO_RST};
      s_reg.scl <= {ssg_pkg::NPT{ssg_pkg::SCL_RST}};
      s_reg.awrdy <= 1'b1;
      s_reg.wrdy <= 1'b1;
      s_reg.arrdy <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // ************************************************************
  // Outputs, all from flip-flops
  // ************************************************************
  assign axi_awready_out = s_reg.awrdy;
  assign axi_wready_out = s_reg.wrdy;
  assign axi_bvalid_out = s_reg.bvalid;
  assign axi_bresp_out = s_reg.bresp;
  assign axi_arready_out = s_reg.arrdy;
  assign axi_rvalid_out = s_reg.rvalid;
  assign axi_rdata_out = s_reg.rdata;
  assign axi_rresp_out = s_reg.rresp;
  assign rsp_out = s_reg.rsp;
  assign cmd_out = s_reg.cmd;
  // RTU is the zero state of the mode bit
  assign transmission_mode_select_out = {s_reg.ctrl[ssg_pkg::CB_STRIDE+ssg_pkg::CB_ASCII],
                                         s_reg.ctrl[ssg_pkg::CB_ASCII]};
  assign link_alarm_out = {pst[1].alarm, pst[0].alarm};
  assign emergency_shutdown_command_out = s_reg.esd_trip;

endmodule // ssg_top

/* File: tb/ssg_mstr_model.sv */
`timescale 1ns/1ns
// ************************************************************
// Link master stand-in for one port
// ************************************************************
module ssg_mstr_model (
  input wire logic clk_in,
  output ssg_pkg::ssg_req_s req_out
);
  // Idle before the first request
  initial req_out = '0;

  // Every transfer starts here, valid for exactly one edge
  // Callers hand over link integers already divided by the scalar
  task automatic send(input logic [7:0] node, input logic [2:0] pfx, input logic [15:0] idx,
                      input logic [15:0] data, input logic err);
    @(posedge clk_in);
    req_out <= '{valid: 1'h1, err: err, err_code: 8'h5a, node: node, pfx: pfx, index: idx, data: data};
    @(posedge clk_in);
    // Released fields other than pfx, valid and err are scrambled so stale values cannot pass
    req_out <= '{valid: 1'h0, err: 1'h0, err_code: 8'ha5, node: ~node, pfx: pfx, index: ~idx, data: ~data};
  endtask
endmodule // ssg_mstr_model

/* File: tb/ssg_top_props.sv */
`timescale 1ns/1ns
// ************************************************************
// Gateway port checks
// ************************************************************
module ssg_top_props (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic axi_awvalid_in,
  input wire logic axi_awready_out,
  input wire logic axi_wvalid_in,
  input wire logic axi_wready_out,
  input wire logic axi_bvalid_out,
  input wire logic axi_arvalid_in,
  input wire logic axi_arready_out,
  input wire logic axi_rvalid_out,
  input wire ssg_pkg::ssg_req_s [1:0] req_in,
  input wire ssg_pkg::ssg_rsp_s [1:0] rsp_out,
  input wire ssg_pkg::ssg_cmd_s [1:0] cmd_out,
  input wire logic [1:0] link_alarm_out,
  input wire logic emergency_shutdown_command_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);

  chk_rsp_cause: assert property (rsp_out[0].valid |-> $past(req_in[0].valid))
    else $error("orphan answer");
  chk_rsp_limit: assert property (rsp_out[0].valid |-> rsp_out[0].data != 16'h8000)
    else $error("out of range");
  chk_coil_cause: assert property (cmd_out[0].coil_valid |->
    $past(req_in[0].valid && !req_in[0].err && req_in[0].pfx == ssg_pkg::PFX_COIL))
    else $error("bad coil cause");
  chk_hold_cause: assert property (cmd_out[0].hold_valid |->
    $past(req_in[0].valid && req_in[0].pfx == ssg_pkg::PFX_HREG))
    else $error("bad hold cause");
  chk_coil_value: assert property (cmd_out[0].coil_valid |-> cmd_out[0].coil_value == $past(req_in[0].data[0])
    && cmd_out[0].index == $past(req_in[0].index))
    else $error("bad coil value");
  chk_esd_cause: assert property (emergency_shutdown_command_out |->
    $past(req_in[0].valid || req_in[1].valid))
    else $error("orphan shutdown");
  // Alarm drops only by a clear write
  chk_alarm_latch: assert property ($fell(link_alarm_out[0]) |->
    $past(!axi_awready_out) || $past(!axi_awready_out, 2))
    else $error("alarm dropped");
  chk_rd_latency: assert property (axi_arvalid_in && axi_arready_out |=> axi_rvalid_out)
    else $error("late read");
  chk_wr_latency: assert property (axi_awvalid_in && axi_awready_out && axi_wvalid_in && axi_wready_out
    |-> ##2 axi_bvalid_out)
    else $error("late write");
  chk_ready_low: assert property (axi_awvalid_in && axi_awready_out |=> !axi_awready_out [*2])
    else $error("early ready");
endmodule // ssg_top_props

bind ssg_top ssg_top_props props_i (.*);

/* File: tb/testbench.sv */
`timescale 1ns/1ns
module testbench;
  logic clk_in = 1'h0;
  logic rst_b_in = 1'h0;
  logic [7:0] axi_awaddr_in = 8'h0, axi_araddr_in = 8'h0;
  logic axi_awvalid_in = 1'h0, axi_wvalid_in = 1'h0, axi_bready_in = 1'h0;
  logic axi_arvalid_in = 1'h0, axi_rready_in = 1'h0, remote_mode_in = 1'h0;
  logic [31:0] axi_wdata_in = 32'h0;
  logic [3:0] axi_wstrb_in = 4'hf;
  logic [15:0] bool_status_in = 16'h0;
  logic [ssg_pkg::NPT-1:0][31:0] proc_analog_in = '0;
  logic axi_awready_out, axi_wready_out, axi_bvalid_out, axi_arready_out, axi_rvalid_out;
  logic emergency_shutdown_command_out;
  logic [1:0] axi_bresp_out, axi_rresp_out, transmission_mode_select_out, link_alarm_out;
  logic [31:0] axi_rdata_out, rd;
  logic [1:0] rr;
  wire ssg_pkg::ssg_req_s [1:0] req_in;
  ssg_pkg::ssg_rsp_s [1:0] rsp_out;
  ssg_pkg::ssg_cmd_s [1:0] cmd_out;
  int mismatches = 0, n_checks = 0;
  // Analog reads: point, value 16.16, scalar 8.8, expected link integer
  int rd_pt [5] = '{0, 1, 2, 3, 0};
  logic [31:0] rd_val [5] = '{32'h0003_8000, 32'hfffc_8000, 32'h7530_0000, 32'h8ad0_0000, 32'h000a_0000};
  logic [15:0] rd_scl [5] = '{16'h0180, 16'h0180, 16'h0200, 16'h0200, 16'h0180};
  logic [15:0] rd_exp [5] = '{16'h5, 16'hfffb, 16'h7fff, 16'h8001, 16'hf};
  // Write gating: port bits, local/remote configured, remote, coil taken
  logic [7:0] gt_ctl [7] = '{8'h00, 8'h02, 8'h01, 8'h03, 8'h03, 8'h03, 8'h07};
  logic [6:0] gt_lr = 7'h70;
  logic [6:0] gt_rm = 7'h20;
  logic [6:0] gt_exp = 7'h68;
  // Shutdown: control word, remote, ack gap (0 = single step), pulse
  logic [31:0] es_ctl [7] = '{32'h1, 32'h9, 32'h1_0009, 32'h1_0009, 32'h1_0019, 32'h2_0009, 32'h2_0009};
  logic [6:0] es_rm = 7'h08;
  int es_gap [7] = '{0, 0, 0, 0, 0, 10, 60};
  logic [6:0] es_exp = 7'h3a;

  // Short counts keep one second at ten cycles
  ssg_top #(.SEC_CYCLES(10), .ESD_ACK_CYCLES(50)) dut (.*);
  ssg_mstr_model mst_a (.clk_in(clk_in), .req_out(req_in[0]));
  ssg_mstr_model mst_b (.clk_in(clk_in), .req_out(req_in[1]));

  // 10 MHz clock
  always #50 clk_in = ~clk_in;

  // ************************************************************
  // Bus and link tasks
  // ************************************************************
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Hung handshake fails the run
  task automatic give_up(input int n);
    if (n >= 20) begin
      mismatches++;
      test_done();
    end
  endtask

  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk_in);
    axi_awaddr_in <= a;
    axi_wdata_in <= d;
    axi_awvalid_in <= 1'h1;
    axi_wvalid_in <= 1'h1;
    axi_bready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
      if (axi_awready_out) axi_awvalid_in <= 1'h0;
      if (axi_wready_out) axi_wvalid_in <= 1'h0;
    end while (axi_bvalid_out !== 1'h1 && n < 20);
    rr = axi_bresp_out;
    axi_bready_in <= 1'h0;
    give_up(n);
  endtask

  task automatic axi_rd(input logic [7:0] a);
    int n = 0;
    @(posedge clk_in);
    axi_araddr_in <= a;
    axi_arvalid_in <= 1'h1;
    axi_rready_in <= 1'h1;
    do begin
      @(posedge clk_in);
      n++;
      if (axi_arready_out) axi_arvalid_in <= 1'h0;
    end while (axi_rvalid_out !== 1'h1 && n < 20);
    rd = axi_rdata_out;
    rr = axi_rresp_out;
    axi_rready_in <= 1'h0;
    give_up(n);
  endtask

  // Outputs looked at half a cycle after the taking edge
  task automatic lnk(input int p, input logic [2:0] pfx, input logic [15:0] idx, input logic [15:0] d,
                     input logic [7:0] node = 8'h01, input logic err = 1'h0);
    if (p == 0) mst_a.send(node, pfx, idx, d, err);
    else mst_b.send(node, pfx, idx, d, err);
    @(negedge clk_in);
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (2) @(posedge clk_in);
    rst_b_in <= 1'h1;
    axi_rd(ssg_pkg::OFF_NODE);
    chk(rd, 32'h0101);
    chk(transmission_mode_select_out, 2'h0);
    axi_rd(8'h40);
    chk(rr, ssg_pkg::RESP_SLVERR);
    axi_wr(8'h44, 32'h1);
    chk(rr, ssg_pkg::RESP_SLVERR);
    axi_wr(ssg_pkg::OFF_CTRL, 32'h2020);
    chk(transmission_mode_select_out, 2'h3);
    lnk(0, ssg_pkg::PFX_IREG, 16'h0, 16'h0, 8'h02);
    chk(rsp_out[0].valid, 1'h0);
    for (int i = 0; i < 5; i++) begin
      @(posedge clk_in);
      proc_analog_in[rd_pt[i]] <= rd_val[i];
      axi_wr(ssg_pkg::OFF_SCL + 8'(4 * rd_pt[i]), {16'h0, rd_scl[i]});
      lnk(0, ssg_pkg::PFX_IREG, 16'(rd_pt[i]), 16'h0);
      chk(rsp_out[0].valid, 1'h1);
      chk(rsp_out[0].data, rd_exp[i]);
    end
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 7; i++) begin
        axi_wr(ssg_pkg::OFF_CTRL, (32'(gt_ctl[i]) << (8 * p)) | (32'(gt_lr[i]) << 16));
        remote_mode_in <= gt_rm[i];
        lnk(p, ssg_pkg::PFX_COIL, 16'h0005, 16'h0001);
        chk(cmd_out[p].coil_valid, gt_exp[i]);
        if (gt_exp[i]) chk({cmd_out[p].index, 15'h0, cmd_out[p].coil_value}, 32'h0005_0001);
      end
    end
    // Holding writes pass in local mode; scalar 1.5 times 4
    axi_wr(ssg_pkg::OFF_CTRL, 32'h1_0003);
    remote_mode_in <= 1'h0;
    lnk(0, ssg_pkg::PFX_HREG, 16'h0000, 16'h0004);
    chk(cmd_out[0].hold_valid, 1'h1);
    chk(cmd_out[0].hold_value, 32'h6_0000);
    for (int i = 0; i < 7; i++) begin
      axi_wr(ssg_pkg::OFF_CTRL, es_ctl[i]);
      remote_mode_in <= es_rm[i];
      lnk(0, ssg_pkg::PFX_COIL, ssg_pkg::IDX_ESD, 16'h0001);
      chk(emergency_shutdown_command_out, (es_gap[i] == 0) ? es_exp[i] : 1'h0);
      if (es_gap[i] > 0) begin
        repeat (es_gap[i]) @(posedge clk_in);
        lnk(0, ssg_pkg::PFX_COIL, ssg_pkg::IDX_ESD_ACK, 16'h0001);
        chk(emergency_shutdown_command_out, es_exp[i]);
      end
    end
    // Two-second timeout on port a, kept alive by traffic
    axi_wr(ssg_pkg::OFF_CTRL, 32'h0);
    axi_wr(ssg_pkg::OFF_TMO, 32'h00ff_0002);
    axi_wr(ssg_pkg::OFF_CMD, 32'h1);
    for (int i = 0; i < 4; i++) begin
      repeat (15) @(posedge clk_in);
      lnk(0, ssg_pkg::PFX_IREG, 16'h0, 16'h0);
    end
    chk(link_alarm_out[0], 1'h0);
    repeat (45) @(posedge clk_in);
    chk(link_alarm_out[0], 1'h1);
    lnk(0, 3'h2, 16'h0, 16'h0);
    lnk(1, ssg_pkg::PFX_IREG, 16'h0, 16'h0, 8'h01, 1'h1);
    axi_rd(ssg_pkg::OFF_STAT);
    chk(rd & 32'h0d, 32'h0d);
    axi_rd(ssg_pkg::OFF_ERR);
    chk(rd & 32'hffff, 32'h5a01);
    axi_wr(ssg_pkg::OFF_CMD, 32'h1);
    axi_rd(ssg_pkg::OFF_STAT);
    chk(rd & 32'h0f, 32'h0);
    test_done();
  end
endmodule // testbench
